// ==== logic/safety_self_test_unit.sv ====
module safety_self_test_unit #(
	parameter int SETTLE_CYCLES = safety_pkg::SETTLE_CYC,
	parameter int SLAVE_CYCLES  = safety_pkg::SLAVE_CYC
) (
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	input  wire logic        rx_valid,
	input  wire logic        rx_ch,
	input  wire logic [1:0]  rx_slot,
	input  wire logic [15:0] rx_data,
	input  wire logic        data_read,
	input  wire logic        data_read_ch,
	output logic      [21:0] data_frame,
	input  wire logic [1:0]  line_undervoltage,
	input  wire logic [1:0]  battery_short,
	input  wire logic [1:0]  ground_short,
	input  wire logic        supply_undervoltage,
	input  wire logic        clock_error,
	input  wire logic        monitor_echo,
	input  wire logic        parity_fault,
	input  wire logic        clock_fault_reaction,
	input  wire logic [1:0]  sensor_line_on,
	input  wire logic [1:0]  line_on_cmd,
	input  wire logic        supply_off_cmd,
	input  wire logic [1:0]  dout_in,
	output logic      [1:0]  dout,
	output logic      [1:0]  line_on_req,
	output logic             supply_off_req,
	output logic      [1:0]  xct_line_enable,
	output logic      [1:0]  discharge_current,
	output logic      [1:0]  short_mask,
	output logic             force_crc_fault,
	output logic             force_tag_mismatch,
	output logic             monitor_stimulus,
	output logic             device_reset_req
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [8:0] sync_a;
	logic [8:0] sync_b;
	logic [1:0] uv_s;
	logic [1:0] stb_s;
	logic [1:0] stg_s;
	logic       vas_uv_s;
	logic       clk_err_s;
	logic       echo_s;

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sync_a <= '0;
			sync_b <= '0;
		end
		else
		begin
			sync_a <= {monitor_echo, clock_error, supply_undervoltage, ground_short, battery_short,
				line_undervoltage};
			sync_b <= sync_a;
		end
	end
	assign {echo_s, clk_err_s, vas_uv_s, stg_s, stb_s, uv_s} = sync_b;

	////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [15:0] setting;
	logic [2:0]  sub_reg;
	logic [1:0]  control;
	logic [4:0]  slot_tag [0:7];
	logic        wr_set;
	logic        start_req;
	logic        abort_req;
	logic        status_rd;
	logic [15:0] status_word;

	function automatic logic tag_hit(input logic [3:0] addr);
		return addr >= safety_pkg::ADDR_TAG_BASE && addr <= safety_pkg::ADDR_TAG_LAST;
	endfunction

	function automatic logic [2:0] tag_index(input logic [3:0] addr);
		return 3'(addr - safety_pkg::ADDR_TAG_BASE);
	endfunction

	assign wr_set    = reg_write && reg_addr == safety_pkg::ADDR_SETTING;
	assign start_req = wr_set && reg_wdata[safety_pkg::SET_START];
	assign abort_req = wr_set && reg_wdata[safety_pkg::SET_ABORT];
	assign status_rd = reg_read && reg_addr == safety_pkg::ADDR_STATUS;

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			setting <= '0;
			sub_reg <= '0;
			control <= '0;
			for (int i = 0; i < 8; i++)
				slot_tag[i] <= '0;
		end
		else if (reg_write)
		begin
			if (reg_addr == safety_pkg::ADDR_SETTING)
				setting <= reg_wdata & ~16'h0005;
			if (reg_addr == safety_pkg::ADDR_SUB)
				sub_reg <= reg_wdata[2:0];
			if (reg_addr == safety_pkg::ADDR_CONTROL)
				control <= reg_wdata[1:0];
			if (tag_hit(reg_addr))
				slot_tag[tag_index(reg_addr)] <= reg_wdata[4:0];
		end
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			reg_rdata <= '0;
		else if (reg_read)
		begin
			case (reg_addr)
				safety_pkg::ADDR_SETTING: reg_rdata <= setting;
				safety_pkg::ADDR_SUB:     reg_rdata <= {13'h0000, sub_reg};
				safety_pkg::ADDR_CONTROL: reg_rdata <= {14'h0000, control};
				safety_pkg::ADDR_STATUS:  reg_rdata <= status_word;
				default:
					reg_rdata <= tag_hit(reg_addr) ? {11'h000, slot_tag[tag_index(reg_addr)]} : '0;
			endcase
		end
	end

	assign force_crc_fault    = control[safety_pkg::CTL_SELF] & sub_reg[safety_pkg::SUB_CRC];
	assign force_tag_mismatch = control[safety_pkg::CTL_SELF] & sub_reg[safety_pkg::SUB_TAG];

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			device_reset_req <= 1'b0;
		else
			device_reset_req <= clk_err_s & ~clock_fault_reaction;
	end

	////////////////////////////////////////////////////////////////////////////
	// Data buffers and empty check
	logic [20:0] buffer [0:1];
	logic [1:0]  check_pend;
	logic [1:0]  be_fault;
	logic        diag_bit;

	assign diag_bit = vas_uv_s | parity_fault;

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			buffer[0]  <= {5'h00, safety_pkg::EMPTY_CODE};
			buffer[1]  <= {5'h00, safety_pkg::EMPTY_CODE};
			data_frame <= '0;
			check_pend <= '0;
		end
		else
		begin
			check_pend <= '0;
			if (rx_valid)
				buffer[rx_ch] <= {slot_tag[{rx_ch, rx_slot}], rx_data};
			if (data_read)
			begin
				data_frame <= control[safety_pkg::CTL_TAG_EN]
					? {diag_bit, buffer[data_read_ch]}
					: {6'h00, buffer[data_read_ch][15:0]};
				if (!sub_reg[safety_pkg::SUB_BUF])
					buffer[data_read_ch] <= {5'h00, safety_pkg::EMPTY_CODE};
				check_pend[data_read_ch] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			be_fault <= '0;
		else
			for (int c = 0; c < 2; c++)
				be_fault[c] <= (be_fault[c] & ~status_rd)
					| (check_pend[c] & buffer[c][15:0] != safety_pkg::EMPTY_CODE);
	end

	////////////////////////////////////////////////////////////////////////////
	// Data output test mode
	logic [1:0] test_sel;

	assign test_sel[0] = setting[safety_pkg::SEL_HI:safety_pkg::SEL_LO] == safety_pkg::SEL_OUT1;
	assign test_sel[1] = setting[safety_pkg::SEL_HI:safety_pkg::SEL_LO] == safety_pkg::SEL_OUT2;

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			dout <= '0;
		else
			for (int c = 0; c < 2; c++)
				dout[c] <= test_sel[c] ? setting[safety_pkg::SET_LEVEL] : dout_in[c];
	end

	////////////////////////////////////////////////////////////////////////////
	// Run-time monitor check
	localparam int MON_W_L = safety_pkg::MON_W;
	logic [MON_W_L-1:0] mon_cnt;
	logic               mon_fault;

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			mon_cnt <= '0;
		else
			mon_cnt <= (mon_cnt == MON_W_L'(safety_pkg::MON_PERIOD - 1)) ? '0 : mon_cnt + 1'b1;
	end
	assign monitor_stimulus = mon_cnt < MON_W_L'(safety_pkg::MON_PULSE);

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			mon_fault <= 1'b0;
		else
			mon_fault <= (mon_fault & ~status_rd)
				| (mon_cnt == MON_W_L'(safety_pkg::MON_PULSE - 1) & ~echo_s);
	end

	////////////////////////////////////////////////////////////////////////////
	// Cross-coupling sequencer
	safety_pkg::xct_state_t state;
	logic [safety_pkg::CNT_W-1:0] cnt;
	logic [1:0] phase;
	logic [1:0] excluded;
	logic       master;
	logic       ch;
	logic       settle_end;
	logic       disch_end;
	logic       slave_end;
	logic       last_phase;
	logic       busy;

	assign busy       = state != safety_pkg::XS_IDLE;
	assign ch         = phase[0];
	assign settle_end = state == safety_pkg::XS_SETTLE && cnt == safety_pkg::CNT_W'(SETTLE_CYCLES - 1) && !abort_req;
	assign disch_end  = state == safety_pkg::XS_DISCH
		&& cnt == safety_pkg::CNT_W'(safety_pkg::DISCH_CYC - 1) && !abort_req;
	assign slave_end  = state == safety_pkg::XS_SLAVE && cnt == safety_pkg::CNT_W'(SLAVE_CYCLES - 1) && !abort_req;
	assign last_phase = phase == 2'd3 || (phase == 2'd2 && excluded[1]) || (phase == 2'd1 && &excluded);

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state    <= safety_pkg::XS_IDLE;
			cnt      <= '0;
			phase    <= '0;
			excluded <= '0;
			master   <= 1'b0;
		end
		else
		begin
			cnt <= cnt + 1'b1;
			case (state)
				safety_pkg::XS_IDLE:
				begin
					cnt      <= '0;
					phase    <= '0;
					excluded <= '0;
					master   <= reg_wdata[safety_pkg::SET_MASTER];
					if (start_req && sensor_line_on == 2'b00)
						state <= reg_wdata[safety_pkg::SET_MASTER] ? safety_pkg::XS_SETTLE : safety_pkg::XS_SLAVE;
				end
				safety_pkg::XS_SLAVE:
					if (slave_end || abort_req)
						state <= safety_pkg::XS_IDLE;
				safety_pkg::XS_SETTLE:
					if (abort_req)
						state <= safety_pkg::XS_IDLE;
					else if (settle_end)
					begin
						cnt   <= '0;
						state <= safety_pkg::XS_DISCH;
						if (!phase[1] && stb_s[ch])
							excluded[ch] <= 1'b1;
					end
				safety_pkg::XS_DISCH:
					if (abort_req)
						state <= safety_pkg::XS_IDLE;
					else if (disch_end)
					begin
						cnt   <= '0;
						state <= last_phase ? safety_pkg::XS_IDLE : safety_pkg::XS_SETTLE;
						phase <= (phase == 2'd1 && excluded[0]) ? 2'd3 : phase + 2'd1;
					end
				default:
					state <= safety_pkg::XS_IDLE;
			endcase
		end
	end

	assign xct_line_enable   = (state == safety_pkg::XS_SETTLE) ? (ch ? 2'b10 : 2'b01) : 2'b00;
	assign short_mask        = xct_line_enable;
	assign discharge_current = (state == safety_pkg::XS_SLAVE) ? 2'b11
		: (state == safety_pkg::XS_DISCH) ? (ch ? 2'b10 : 2'b01) : 2'b00;
	assign line_on_req       = busy ? 2'b00 : line_on_cmd;
	assign supply_off_req    = supply_off_cmd & ~busy;

	////////////////////////////////////////////////////////////////////////////
	// Test results
	logic       done;
	logic       aborted;
	logic       held;
	logic [1:0] stb_res;
	logic [1:0] stg_res;
	logic [1:0] slv_fail;
	logic [1:0] xc_res;
	logic       clr;
	logic       m_done;

	assign clr    = status_rd | start_req;
	assign m_done = disch_end & last_phase;

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			{done, aborted, held, stb_res, stg_res, slv_fail, xc_res} <= '0;
		end
		else
		begin
			done     <= (done & ~clr) | slave_end | m_done;
			aborted  <= (aborted & ~clr) | (abort_req & master & busy);
			held     <= (held & ~clr) | m_done;
			slv_fail <= (slv_fail & {2{~clr}}) | ({2{slave_end}} & ~uv_s);
			for (int c = 0; c < 2; c++)
			begin
				stb_res[c] <= (stb_res[c] & ~clr) | (settle_end & !phase[1] & ch == c[0] & stb_s[c]);
				stg_res[c] <= (stg_res[c] & ~clr) | (settle_end & phase[1] & ch == c[0] & uv_s[c]);
				xc_res[c]  <= (xc_res[c] & ~clr) | (settle_end & phase[1] & ch != c[0] & ~uv_s[c]);
			end
		end
	end

	always_comb
	begin
		status_word = '0;
		for (int c = 0; c < 2; c++)
		begin
			status_word[safety_pkg::ST_STG + 8 * c] = held ? stg_res[c] : stg_s[c];
			status_word[safety_pkg::ST_BE + 8 * c]  = be_fault[c];
			status_word[safety_pkg::ST_STB + 8 * c] = stb_res[c];
			status_word[safety_pkg::ST_SLV + 8 * c] = slv_fail[c];
			status_word[safety_pkg::ST_XC + 8 * c]  = xc_res[c];
		end
		status_word[safety_pkg::ST_BUSY]  = busy;
		status_word[safety_pkg::ST_DONE]  = done;
		status_word[safety_pkg::ST_ABORT] = aborted;
		status_word[safety_pkg::ST_MON]   = mon_fault;
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);

	property p_one_test_out;
		!(test_sel[0] && test_sel[1]);
	endproperty
	a_one_test_out: assert property (p_one_test_out) else $error("two outputs in test mode");

	property p_test_level;
		test_sel[0] |=> dout[0] == $past(setting[safety_pkg::SET_LEVEL]);
	endproperty
	a_test_level: assert property (p_test_level) else $error("test level wrong");

	property p_refuse;
		(state == safety_pkg::XS_IDLE && start_req && sensor_line_on != 2'b00) |=> !busy && !done;
	endproperty
	a_refuse: assert property (p_refuse) else $error("start not refused");

	property p_gate;
		busy |-> line_on_req == 2'b00 && !supply_off_req;
	endproperty
	a_gate: assert property (p_gate) else $error("command passed during test");

	property p_abort_slave;
		(state == safety_pkg::XS_SLAVE && abort_req && !aborted) |=> !busy && !aborted;
	endproperty
	a_abort_slave: assert property (p_abort_slave) else $error("slave abort flagged");

	property p_slave_disch;
		slave_end |-> $past(discharge_current, 8) == 2'b11 && discharge_current == 2'b11
			##1 discharge_current == 2'b00 && done;
	endproperty
	a_slave_disch: assert property (p_slave_disch) else $error("slave discharge missing");

	property p_be_fault;
		(data_read && sub_reg[safety_pkg::SUB_BUF] && !rx_valid && !status_rd
			&& buffer[data_read_ch][15:0] != safety_pkg::EMPTY_CODE)
			|-> ##2 be_fault[$past(data_read_ch, 2)];
	endproperty
	a_be_fault: assert property (p_be_fault) else $error("buffer empty fault missed");

	property p_done;
		m_done && !clr |=> done && !busy;
	endproperty
	a_done: assert property (p_done) else $error("done flag missing");

	property p_clear;
		(status_rd && !slave_end && !m_done) |=> !done;
	endproperty
	a_clear: assert property (p_clear) else $error("done not cleared");

	property p_reset_req;
		(clk_err_s && !clock_fault_reaction) |=> device_reset_req;
	endproperty
	a_reset_req: assert property (p_reset_req) else $error("reset not requested");

endmodule

// ==== inc/safety_pkg.sv ====
package safety_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [3:0] ADDR_SETTING  = 4'h0;
	localparam logic [3:0] ADDR_SUB      = 4'h1;
	localparam logic [3:0] ADDR_CONTROL  = 4'h2;
	localparam logic [3:0] ADDR_STATUS   = 4'h3;
	localparam logic [3:0] ADDR_TAG_BASE = 4'h4;
	localparam logic [3:0] ADDR_TAG_LAST = 4'hB;

	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int SET_START   = 0;
	localparam int SET_MASTER  = 1;
	localparam int SET_ABORT   = 2;
	localparam int SEL_LO      = 5;
	localparam int SEL_HI      = 9;
	localparam int SET_LEVEL   = 10;
	localparam int SUB_BUF     = 0;
	localparam int SUB_CRC     = 1;
	localparam int SUB_TAG     = 2;
	localparam int CTL_SELF    = 0;
	localparam int CTL_TAG_EN  = 1;
	localparam int ST_STG      = 0;
	localparam int ST_BE       = 1;
	localparam int ST_STB      = 2;
	localparam int ST_SLV      = 3;
	localparam int ST_XC       = 4;
	localparam int ST_BUSY     = 5;
	localparam int ST_DONE     = 6;
	localparam int ST_ABORT    = 7;
	localparam int ST_CH2      = 8;
	localparam int ST_MON      = 13;

	////////////////////////////////////////////////////////////////////////////
	// Codes and reset values
	localparam logic [4:0]  SEL_OUT1   = 5'h15;
	localparam logic [4:0]  SEL_OUT2   = 5'h16;
	localparam logic [15:0] EMPTY_CODE = 16'h01f0;
	localparam logic [15:0] ZERO_WORD  = 16'h0000;

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_MHZ   = 10;
	localparam int SETTLE_US = 512;
	localparam int SLAVE_US  = 512;
	localparam int DISCH_US  = 128;
	localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
	localparam int SLAVE_CYC  = SLAVE_US * CLK_MHZ;
	localparam int DISCH_CYC  = DISCH_US * CLK_MHZ;
	localparam int CNT_W      = 13;
	localparam int MON_PERIOD = 1000;
	localparam int MON_PULSE  = 10;
	localparam int MON_W      = 10;

	typedef enum logic [1:0]
	{
		XS_IDLE   = 2'b00,
		XS_SLAVE  = 2'b01,
		XS_SETTLE = 2'b10,
		XS_DISCH  = 2'b11
	} xct_state_t;

endpackage

// ==== sim/mcu_model.sv ====
module mcu_model (
	input  wire logic        clock,
	output logic             reg_write,
	output logic             reg_read,
	output logic      [3:0]  reg_addr,
	output logic      [15:0] reg_wdata,
	input  wire logic [15:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ns;

	initial
	begin
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////////
	// Register access; released lines show inverted values
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_write <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clock);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'b0;
		reg_addr <= ~a;
		@(posedge clock);
		d = reg_rdata;
	endtask
endmodule

// ==== sim/safety_self_test_unit_tb.sv ====
module safety_self_test_unit_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clock;
	logic        reset_n;
	logic        reg_write;
	logic        reg_read;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic        rx_valid = 1'b0;
	logic        rx_ch = 1'b0;
	logic [1:0]  rx_slot = 2'b00;
	logic [15:0] rx_data = 16'h0000;
	logic        data_read = 1'b0;
	logic        data_read_ch = 1'b0;
	logic [21:0] data_frame;
	logic [1:0]  line_undervoltage = 2'b00;
	logic [1:0]  battery_short = 2'b00;
	logic [1:0]  ground_short = 2'b00;
	logic        supply_undervoltage = 1'b0;
	logic        clock_error = 1'b0;
	logic        monitor_echo = 1'b0;
	logic        parity_fault = 1'b0;
	logic        clock_fault_reaction = 1'b0;
	logic [1:0]  sensor_line_on = 2'b00;
	logic [1:0]  line_on_cmd = 2'b00;
	logic        supply_off_cmd = 1'b0;
	logic [1:0]  dout_in = 2'b00;
	logic [1:0]  dout;
	logic [1:0]  line_on_req;
	logic        supply_off_req;
	logic [1:0]  xct_line_enable;
	logic [1:0]  discharge_current;
	logic [1:0]  short_mask;
	logic        force_crc_fault;
	logic        force_tag_mismatch;
	logic        monitor_stimulus;
	logic        device_reset_req;
	logic        echo_break = 1'b0;
	logic [15:0] s;
	logic [21:0] f;
	int          error_cnt = 0;
	int          comparisons = 0;
	int          cyc = 0;

	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	safety_self_test_unit #(.SETTLE_CYCLES(40), .SLAVE_CYCLES(40)) dut (.*);
	mcu_model mcu (.clock(clock), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	////////////////////////////////////////////////////////////////////////////
	// Monitor echo loops the stimulus back unless broken
	always @(posedge clock)
	begin
		monitor_echo <= monitor_stimulus & ~echo_break;
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		if (got !== exp)
			error_cnt++;
	endtask

	task automatic rx(input logic c, input logic [1:0] sl, input logic [15:0] d);
		@(posedge clock);
		rx_valid <= 1'b1;
		rx_ch <= c;
		rx_slot <= sl;
		rx_data <= d;
		@(posedge clock);
		rx_valid <= 1'b0;
		rx_data <= ~d;
	endtask

	task automatic rdbuf(input logic c);
		@(posedge clock);
		data_read <= 1'b1;
		data_read_ch <= c;
		@(posedge clock);
		data_read <= 1'b0;
		@(posedge clock);
		f = data_frame;
	endtask

	task automatic tally_and_finish();
		$display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_dout();
		logic [4:0] sel [4] = '{5'h15, 5'h16, 5'h15, 5'h14};
		logic       lvl [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
		logic [1:0] din [4] = '{2'b00, 2'b11, 2'b10, 2'b01};
		logic [1:0] exp [4] = '{2'b01, 2'b01, 2'b10, 2'b01};
		for (int i = 0; i < 4; i++)
		begin
			dout_in <= din[i];
			mcu.wr(safety_pkg::ADDR_SETTING, {5'h00, lvl[i], sel[i], 5'h00});
			repeat (4) @(posedge clock);
			chk(dout, exp[i]);
		end
		mcu.wr(safety_pkg::ADDR_SETTING, 16'h0000);
		$display("test dout done");
	endtask

	task automatic t_buffer();
		rx(1'b0, 2'd1, 16'h1234);
		rdbuf(1'b0);
		chk(f, 22'h00_1234);
		rdbuf(1'b0);
		chk(f, 22'h00_01f0);
		mcu.rd(safety_pkg::ADDR_STATUS, s);
		chk(s[1], 1'b0);
		mcu.wr(safety_pkg::ADDR_SUB, 16'h0001);
		rx(1'b1, 2'd2, 16'h0abc);
		rdbuf(1'b1);
		rdbuf(1'b1);
		chk(f, 22'h00_0abc);
		repeat (3) @(posedge clock);
		mcu.rd(safety_pkg::ADDR_STATUS, s);
		chk(s[9], 1'b1);
		mcu.rd(safety_pkg::ADDR_STATUS, s);
		chk(s[9], 1'b0);
		mcu.wr(safety_pkg::ADDR_SUB, 16'h0000);
		mcu.wr(safety_pkg::ADDR_CONTROL, 16'h0002);
		mcu.wr(4'h9, 16'h001a);
		parity_fault <= 1'b1;
		rx(1'b1, 2'd1, 16'h5555);
		rdbuf(1'b1);
		chk(f, {1'b1, 5'h1a, 16'h5555});
		parity_fault <= 1'b0;
		mcu.wr(safety_pkg::ADDR_CONTROL, 16'h0000);
		$display("test buffer done");
	endtask

	task automatic t_self();
		mcu.wr(safety_pkg::ADDR_CONTROL, 16'h0001);
		mcu.wr(safety_pkg::ADDR_SUB, 16'h0006);
		@(posedge clock);
		chk({force_crc_fault, force_tag_mismatch}, 2'b11);
		mcu.wr(safety_pkg::ADDR_SUB, 16'h0000);
		mcu.wr(safety_pkg::ADDR_CONTROL, 16'h0000);
		clock_error <= 1'b1;
		repeat (6) @(posedge clock);
		chk(device_reset_req, 1'b1);
		clock_fault_reaction <= 1'b1;
		repeat (6) @(posedge clock);
		chk(device_reset_req, 1'b0);
		clock_error <= 1'b0;
		clock_fault_reaction <= 1'b0;
		$display("test self done");
	endtask

	task automatic t_slave();
		line_undervoltage <= 2'b01;
		line_on_cmd <= 2'b11;
		supply_off_cmd <= 1'b1;
		mcu.wr(safety_pkg::ADDR_SETTING, 16'h0001);
		@(posedge clock);
		chk(discharge_current, 2'b11);
		chk(line_on_req, 2'b00);
		chk(supply_off_req, 1'b0);
		mcu.rd(safety_pkg::ADDR_STATUS, s);
		chk(s[5], 1'b1);
		repeat (51) @(posedge clock);
		chk(discharge_current, 2'b00);
		chk(line_on_req, 2'b11);
		chk(supply_off_req, 1'b1);
		mcu.rd(safety_pkg::ADDR_STATUS, s);
		chk({s[11], s[6], s[5], s[3]}, 4'b1100);
		mcu.rd(safety_pkg::ADDR_STATUS, s);
		chk(s[6], 1'b0);
		line_on_cmd <= 2'b00;
		supply_off_cmd <= 1'b0;
		line_undervoltage <= 2'b00;
		$display("test slave done");
	endtask

	task automatic t_abort();
		sensor_line_on <= 2'b01;
		mcu.wr(safety_pkg::ADDR_SETTING, 16'h0001);
		repeat (3) @(posedge clock);
		mcu.rd(safety_pkg::ADDR_STATUS, s);
		chk(s[5], 1'b0);
		sensor_line_on <= 2'b00;
		mcu.wr(safety_pkg::ADDR_SETTING, 16'h0001);
		mcu.wr(safety_pkg::ADDR_SETTING, 16'h0004);
		mcu.rd(safety_pkg::ADDR_STATUS, s);
		chk({s[7], s[5]}, 2'b00);
		mcu.wr(safety_pkg::ADDR_SETTING, 16'h0003);
		repeat (100) @(posedge clock);
		mcu.wr(safety_pkg::ADDR_SETTING, 16'h0004);
		mcu.rd(safety_pkg::ADDR_STATUS, s);
		chk({s[7], s[5]}, 2'b10);
		$display("test abort done");
	endtask

	task automatic t_master();
		mcu.wr(safety_pkg::ADDR_SETTING, 16'h0003);
		repeat (6) @(posedge clock);
		chk(xct_line_enable, 2'b01);
		chk(short_mask, 2'b01);
		repeat (40) @(posedge clock);
		chk({xct_line_enable, discharge_current}, 4'b0001);
		repeat (1280) @(posedge clock);
		chk({xct_line_enable, discharge_current}, 4'b1000);
		repeat (4080) @(posedge clock);
		mcu.rd(safety_pkg::ADDR_STATUS, s);
		chk(s, 16'h1050);
		mcu.rd(safety_pkg::ADDR_STATUS, s);
		chk(s, 16'h0000);
		ground_short <= 2'b11;
		repeat (4) @(posedge clock);
		mcu.rd(safety_pkg::ADDR_STATUS, s);
		chk({s[8], s[0]}, 2'b11);
		ground_short <= 2'b00;
		echo_break <= 1'b1;
		repeat (1100) @(posedge clock);
		mcu.rd(safety_pkg::ADDR_STATUS, s);
		chk(s[13], 1'b1);
		echo_break <= 1'b0;
		$display("test master done");
	endtask

	initial
	begin
		reset_n = 1'b0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		t_dout();
		t_buffer();
		t_self();
		t_slave();
		t_abort();
		t_master();
		tally_and_finish();
	end
endmodule
